// File: design/io_port_pkg.sv
// Shared constants and types for the I/O port pin function mux
package io_port_pkg;

    // ------------------------------------------------------------
    // Pin counts and indices
    // ------------------------------------------------------------
    localparam int NUM_A    = 8;
    localparam int NUM_B    = 6;
    localparam int NUM_PINS = 14;
    localparam int PIN_PA0  = 0;
    localparam int PIN_PA1  = 1;
    localparam int PIN_PA2  = 2;
    localparam int PIN_PA4  = 4;
    localparam int PIN_PA5  = 5;
    localparam int PIN_PA6  = 6;
    localparam int PIN_PA7  = 7;
    localparam int PIN_PB0  = 8;
    localparam int PIN_PB1  = 9;
    localparam int PIN_PB2  = 10;
    localparam int PIN_PB3  = 11;
    localparam int PIN_PB5  = 13;

    // ------------------------------------------------------------
    // Field positions and capability masks
    // ------------------------------------------------------------
    localparam int PL_PA_LSB = 0;     // Shared pull-low bits 3..0 -> PA3..PA0
    localparam int PL_PB_LSB = 4;     // Shared pull-low bits 7..4 -> PB3..PB0
    localparam logic [NUM_A-1:0]    PA_PH_MASK = 8'hDF;
    localparam logic [NUM_PINS-1:0] OD_FORCED  = 14'h0020;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [NUM_A-1:0]    DATA_A_RST = 8'h00;
    localparam logic [NUM_B-1:0]    DATA_B_RST = 6'h00;
    localparam logic [NUM_PINS-1:0] PIN_RST    = 14'h0000;
    localparam logic                FLAG_RST   = 1'h0;

    // Per-pin request into the pad driver
    typedef struct packed {
        logic [NUM_PINS-1:0] drive;   // Pin driven as output
        logic [NUM_PINS-1:0] val;     // Value to present
        logic [NUM_PINS-1:0] od;      // Open-drain drive
    } pad_req_t;

    // Registered pad drive
    typedef struct packed {
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] out;
    } pad_drv_t;

endpackage : io_port_pkg

// File: design/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and change pulse
`timescale 1ns/100ps
module pin_sync
    import io_port_pkg::*;
#(
    parameter int WIDTH = NUM_PINS
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Raw pins
    input  wire logic [WIDTH-1:0] rawIn,
    // Filtered level and change pulse
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] change
);

    logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, chg_ff;
    logic [WIDTH-1:0] nxt_lvl, nxt_chg;

    // ------------------------------------------------------------
    // Next level: accept once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        nxt_lvl = lvl_ff;
        nxt_chg = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if ((s2_ff[i] == s3_ff[i]) && (s3_ff[i] != lvl_ff[i])) begin
                nxt_lvl[i] = s3_ff[i];
                nxt_chg[i] = 1'b1;
            end
        end
    end

    // Sync chain and filtered level
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff  <= PIN_RST[WIDTH-1:0];
            s2_ff  <= PIN_RST[WIDTH-1:0];
            s3_ff  <= PIN_RST[WIDTH-1:0];
            lvl_ff <= PIN_RST[WIDTH-1:0];
            chg_ff <= PIN_RST[WIDTH-1:0];
        end else begin
            s1_ff  <= rawIn;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
            chg_ff <= nxt_chg;
        end
    end

    assign level  = lvl_ff;
    assign change = chg_ff;

endmodule : pin_sync

// File: design/pad_drive.sv
// Per-pin push-pull / open-drain drive, registered
`timescale 1ns/100ps
module pad_drive
    import io_port_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // Drive request
    input  pad_req_t      req,
    // Registered pad drive
    output pad_drv_t      drv
);

    pad_drv_t drv_ff, nxt_drv;

    // ------------------------------------------------------------
    // Drive decode, one cell per pin
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_cell
        always_comb begin
            if (!req.drive[i]) begin
                nxt_drv.oe[i]  = 1'b0;            // Input: released
                nxt_drv.out[i] = 1'b0;
            end else if (req.od[i]) begin
                nxt_drv.oe[i]  = !req.val[i];     // Sink only on low
                nxt_drv.out[i] = 1'b0;
            end else begin
                nxt_drv.oe[i]  = 1'b1;
                nxt_drv.out[i] = req.val[i];
            end
        end
    end

    // Drive register
    always_ff @(posedge clk) begin
        if (rst) begin
            drv_ff <= '0;
        end else begin
            drv_ff <= nxt_drv;
        end
    end

    assign drv = drv_ff;

endmodule : pad_drive

// File: design/io_port_pin_function_mux.sv
// Fourteen-pin GPIO port with pulls, open-drain, change flag and pin muxing
// Function
// [R01] Fourteen pins PA7..0, PB5..0, readable and writable through data regs.
// [R02] One direction bit per pin: eight for port A, six for port B.
// [R03] Per-pin pull-high enables for PA7,6,4..0 and PB5..0 on inputs.
// [R04] Pull-low: PA5 from A pull-high bit5, PA3..0 and PB3..0 shared reg.
// [R05] Pull resistors apply only while the pin is an input.
// [R06] Port B output pins may be individually open-drain.
// [R07] PA5 no pull-high, always open-drain; several pins lack pull-low.
// [R08] Wake enable bits pick pins whose level change sets change flag.
// [R09] Change interrupt only with flag, its enable and global enable set.
// [R10] Select bits route PB0 and PB1 as external interrupts 0 and 1.
// [R11] External interrupt on PB0/PB1 disables that pin's change detect.
// [R12] IR carrier drives PB1 only while IR enable is one.
// [R13] Configured PA5 is active-low external reset input.
// [R14] Crystal mode takes PA6 as crystal input, PA7 as output.
// [R15] Internal oscillator, no crystal: instruction clock out on PA7.
// [R16] PA4 feeds timer zero and one clock, PA1 feeds timer three.
// [R17] PB3 priority: comparator, then PWM1, then buzzer one.
// [R18] PWM2 drives PB2 or PA0 when enabled.
// [R19] PWM4 drives PA2 or PB5 when enabled, else GPIO.
// [R20] PWM5 drives PB0 or PA1 when enabled, else GPIO.
// [R21] PWM4/PWM5 polarity one makes the output active low.
// [R22] Per-pin read type picks pin level or output latch on read.
// [R23] Pins synchronised; change found by comparing with previous sample.
// [R24] Change flag sticks until written zero; new detect beats clear.
`timescale 1ns/100ps
module io_port_pin_function_mux
    import io_port_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Pads: input level, output value, output enable
    input  wire logic [NUM_PINS-1:0] padIn,
    output logic      [NUM_PINS-1:0] padOut,
    output logic      [NUM_PINS-1:0] padOe,
    output logic      [NUM_PINS-1:0] pullHighEn,
    output logic      [NUM_PINS-1:0] pullLowEn,
    // Data latch writes
    input  wire logic                portAWr,
    input  wire logic [NUM_A-1:0]    portAWrData,
    input  wire logic                portBWr,
    input  wire logic [NUM_B-1:0]    portBWrData,
    // Data reads
    output logic      [NUM_A-1:0]    portADataRd,
    output logic      [NUM_B-1:0]    portBDataRd,
    input  wire logic [NUM_PINS-1:0] readLatchSel,
    // Pin configuration
    input  wire logic [NUM_A-1:0]    portADirection,
    input  wire logic [NUM_B-1:0]    portBDirection,
    input  wire logic [NUM_A-1:0]    portAPullhighCtrl,
    input  wire logic [NUM_B-1:0]    portBPullhighCtrl,
    input  wire logic [7:0]          sharedPulllowCtrl,
    input  wire logic [NUM_B-1:0]    portBOpendrainCtrl,
    // Change interrupt
    input  wire logic [NUM_A-1:0]    portAWakeEnable,
    input  wire logic [NUM_B-1:0]    portBWakeEnable,
    input  wire logic                portChangeIntEnable,
    input  wire logic                globalIntEnable,
    input  wire logic                portChangeFlagClr,
    output logic                     portChangeFlag,
    output logic                     portChangeIrq,
    // External interrupts
    input  wire logic                extInt0Select,
    input  wire logic                extInt1Select,
    output logic                     extInt0,
    output logic                     extInt1,
    // Configuration word and oscillator
    input  wire logic                resetPinCfg,
    input  wire logic                extHighCrystal,
    input  wire logic                extLowCrystal,
    input  wire logic                internalHighRc,
    input  wire logic                internalLowRc,
    input  wire logic                clkOutCfg,
    input  wire logic                instrClk,
    output logic                     extResetReqN,
    output logic                     crystalPinsEn,
    // Timer clock inputs
    input  wire logic                timerZeroSourceSel,
    input  wire logic                timerZeroLowclkSel,
    input  wire logic                timerOneSourceSel,
    input  wire logic                timerThreeSourceSel,
    output logic                     timerZeroExtClk,
    output logic                     timerOneExtClk,
    output logic                     timerThreeExtClk,
    // Alternate outputs
    input  wire logic                irCarrierEnable,
    input  wire logic                irCarrier,
    input  wire logic                comparatorPinEnable,
    input  wire logic                comparatorOut,
    input  wire logic                pwmOneOutEnable,
    input  wire logic                pwmOneOnPa4,
    input  wire logic                pwmOne,
    input  wire logic                buzzerOneEnable,
    input  wire logic                buzzerOne,
    input  wire logic                pwmTwoOutEnable,
    input  wire logic                pwmTwoOnPa0,
    input  wire logic                pwmTwo,
    input  wire logic                pwmFourOutEnable,
    input  wire logic                pwmFourActiveLow,
    input  wire logic                pwmFourOnPb5,
    input  wire logic                pwmFour,
    input  wire logic                pwmFiveOutEnable,
    input  wire logic                pwmFiveActiveLow,
    input  wire logic                pwmFiveOnPa1,
    input  wire logic                pwmFive
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NUM_A-1:0]    dataA_ff, nxt_dataA;
    logic [NUM_B-1:0]    dataB_ff, nxt_dataB;
    logic [NUM_PINS-1:0] pinLevel, pinChange, latchAll, isInput, wakeMask;
    logic [NUM_PINS-1:0] altEn, altVal, phCap, plCap, nxt_ph, nxt_pl;
    logic [NUM_PINS-1:0] ph_ff, pl_ff, rd_ff, nxt_rd;
    logic                flag_ff, nxt_flag, rstN_ff, nxt_rstN;
    logic                crystal, clkOut, pwmFourVal, pwmFiveVal, wakeHit;
    pad_req_t            req;
    pad_drv_t            drv;

    // Selects the latch bit or the pin level per pin
    function automatic logic [NUM_PINS-1:0] readMux(
        input logic [NUM_PINS-1:0] sel,
        input logic [NUM_PINS-1:0] latchV,
        input logic [NUM_PINS-1:0] pinV);
        readMux = (sel & latchV) | (~sel & pinV);
    endfunction : readMux

    // ------------------------------------------------------------
    // Pin synchroniser and pad driver
    // ------------------------------------------------------------
    pin_sync #(.WIDTH(NUM_PINS)) pin_sync_i (
        .clk    (clk),
        .rst    (rst),
        .rawIn  (padIn),
        .level  (pinLevel),
        .change (pinChange)                        // [R23]
    );

    pad_drive pad_drive_i (
        .clk (clk),
        .rst (rst),
        .req (req),
        .drv (drv)
    );

    assign padOut = drv.out;
    assign padOe  = drv.oe;

    // ------------------------------------------------------------
    // Data latches
    // ------------------------------------------------------------
    always_comb begin
        nxt_dataA = portAWr ? portAWrData : dataA_ff;   // [R01]
        nxt_dataB = portBWr ? portBWrData : dataB_ff;   // [R01]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataA_ff <= DATA_A_RST;
            dataB_ff <= DATA_B_RST;
        end else begin
            dataA_ff <= nxt_dataA;
            dataB_ff <= nxt_dataB;
        end
    end

    assign latchAll = {dataB_ff, dataA_ff};
    assign isInput  = {portBDirection, portADirection};  // [R02] 1 = input

    // ------------------------------------------------------------
    // Alternate function steering
    // ------------------------------------------------------------
    always_comb begin
        crystal    = extHighCrystal || extLowCrystal;
        clkOut     = clkOutCfg && !crystal
                     && (internalHighRc || internalLowRc);   // [R15]
        pwmFourVal = pwmFour ^ pwmFourActiveLow;              // [R21]
        pwmFiveVal = pwmFive ^ pwmFiveActiveLow;              // [R21]
        altEn      = '0;
        altVal     = '0;
        altEn[PIN_PA0]  = pwmTwoOutEnable && pwmTwoOnPa0;     // [R18]
        altVal[PIN_PA0] = pwmTwo;
        altEn[PIN_PB2]  = pwmTwoOutEnable && !pwmTwoOnPa0;    // [R18]
        altVal[PIN_PB2] = pwmTwo;
        altEn[PIN_PA2]  = pwmFourOutEnable && !pwmFourOnPb5;  // [R19]
        altVal[PIN_PA2] = pwmFourVal;
        altEn[PIN_PB5]  = pwmFourOutEnable && pwmFourOnPb5;   // [R19]
        altVal[PIN_PB5] = pwmFourVal;
        altEn[PIN_PA1]  = pwmFiveOutEnable && pwmFiveOnPa1;   // [R20]
        altVal[PIN_PA1] = pwmFiveVal;
        altEn[PIN_PB0]  = pwmFiveOutEnable && !pwmFiveOnPa1;  // [R20]
        altVal[PIN_PB0] = pwmFiveVal;
        altEn[PIN_PA4]  = pwmOneOutEnable && pwmOneOnPa4;
        altVal[PIN_PA4] = pwmOne;
        altEn[PIN_PB1]  = irCarrierEnable;                    // [R12]
        altVal[PIN_PB1] = irCarrier;
        altEn[PIN_PA7]  = clkOut;                             // [R15]
        altVal[PIN_PA7] = instrClk;
        // PB3 fixed priority
        if (comparatorPinEnable) begin                        // [R17]
            altEn[PIN_PB3]  = 1'b1;
            altVal[PIN_PB3] = comparatorOut;
        end else if (pwmOneOutEnable && !pwmOneOnPa4) begin   // [R17]
            altEn[PIN_PB3]  = 1'b1;
            altVal[PIN_PB3] = pwmOne;
        end else if (buzzerOneEnable) begin                   // [R17]
            altEn[PIN_PB3]  = 1'b1;
            altVal[PIN_PB3] = buzzerOne;
        end
    end

    // Drive request to the pads
    always_comb begin
        req.drive = altEn | ~isInput;                          // [R02]
        req.val   = (altEn & altVal) | (~altEn & latchAll);
        req.od    = OD_FORCED
                    | {portBOpendrainCtrl, {NUM_A{1'b0}}};     // [R06] [R07]
        if (crystal) begin                                     // [R14]
            req.drive[PIN_PA6] = 1'b0;
            req.drive[PIN_PA7] = 1'b0;
        end
    end

    assign crystalPinsEn = crystal;                            // [R14]

    // ------------------------------------------------------------
    // Pull resistor enables
    // ------------------------------------------------------------
    always_comb begin
        phCap = {portBPullhighCtrl, portAPullhighCtrl & PA_PH_MASK}; // [R03]
        plCap = '0;
        plCap[PIN_PA5] = portAPullhighCtrl[PIN_PA5];                 // [R04]
        plCap[3:0]     = sharedPulllowCtrl[PL_PA_LSB+:4];            // [R04]
        plCap[PIN_PB0+:4] = sharedPulllowCtrl[PL_PB_LSB+:4];         // [R04]
        nxt_ph = phCap & isInput & ~altEn;                           // [R05]
        nxt_pl = plCap & isInput & ~altEn;                           // [R05]
        if (crystal) begin
            nxt_ph[PIN_PA7:PIN_PA6] = 2'h0;
            nxt_pl[PIN_PA7:PIN_PA6] = 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_ff <= PIN_RST;
            pl_ff <= PIN_RST;
        end else begin
            ph_ff <= nxt_ph;
            pl_ff <= nxt_pl;
        end
    end

    assign pullHighEn = ph_ff;
    assign pullLowEn  = pl_ff;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        nxt_rd = readMux(readLatchSel, latchAll, pinLevel);   // [R22]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ff <= PIN_RST;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    assign portADataRd = rd_ff[NUM_A-1:0];                    // [R01]
    assign portBDataRd = rd_ff[NUM_PINS-1:NUM_A];

    // ------------------------------------------------------------
    // Port change flag and interrupt
    // ------------------------------------------------------------
    always_comb begin
        wakeMask = {portBWakeEnable, portAWakeEnable};        // [R08]
        wakeMask[PIN_PB0] = wakeMask[PIN_PB0] && !extInt0Select; // [R11]
        wakeMask[PIN_PB1] = wakeMask[PIN_PB1] && !extInt1Select; // [R11]
        wakeHit  = |(pinChange & wakeMask);                   // [R08]
        nxt_flag = wakeHit || (flag_ff && !portChangeFlagClr); // [R24]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_ff <= FLAG_RST;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign portChangeFlag = flag_ff;
    assign portChangeIrq  = flag_ff && portChangeIntEnable
                            && globalIntEnable;               // [R09]

    // ------------------------------------------------------------
    // External interrupts, timer clocks, reset pin
    // ------------------------------------------------------------
    assign extInt0 = extInt0Select && pinLevel[PIN_PB0];      // [R10]
    assign extInt1 = extInt1Select && pinLevel[PIN_PB1];      // [R10]
    assign timerZeroExtClk  = timerZeroSourceSel && !timerZeroLowclkSel
                              && pinLevel[PIN_PA4];           // [R16]
    assign timerOneExtClk   = timerOneSourceSel && pinLevel[PIN_PA4]; // [R16]
    assign timerThreeExtClk = timerThreeSourceSel
                              && pinLevel[PIN_PA1];           // [R16]

    always_comb begin
        nxt_rstN = !(resetPinCfg && !pinLevel[PIN_PA5]);      // [R13]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rstN_ff <= 1'b1;
        end else begin
            rstN_ff <= nxt_rstN;
        end
    end

    assign extResetReqN = rstN_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_hit;
        wakeHit;
    endsequence

    AST_FLAG_SET: assert property (s_hit |=> portChangeFlag) // [R08]
        else $error("change flag not set by enabled pin change");
    AST_SET_WINS: assert property (wakeHit && portChangeFlagClr
        |=> portChangeFlag) // [R24]
        else $error("clear beat a new change detection");
    AST_FLAG_STICKY: assert property (portChangeFlag && !portChangeFlagClr
        |=> portChangeFlag) // [R24]
        else $error("change flag dropped without clear");
    AST_IRQ_GATE: assert property (portChangeIrq
        |-> portChangeFlag && portChangeIntEnable && globalIntEnable) // [R09]
        else $error("interrupt without flag and both enables");
    AST_EXT0_MASK: assert property (extInt0Select && portBWakeEnable == 6'h01
        && portAWakeEnable == 8'h00 && !flag_ff |=> !portChangeFlag) // [R11]
        else $error("PB0 change flagged while used as external interrupt");
    AST_PULL_INPUT: assert property (1'b1 |=> ((pullHighEn | pullLowEn)
        & ~$past(isInput)) == 14'h0000) // [R05]
        else $error("pull enabled on an output pin");
    AST_PA5_NOPH: assert property (!pullHighEn[PIN_PA5]) // [R07]
        else $error("PA5 pull-high enabled");
    AST_PA5_OD: assert property (padOe[PIN_PA5] |-> !padOut[PIN_PA5]) // [R07]
        else $error("PA5 driven high");
    AST_CRYSTAL: assert property (crystal ##1 crystal
        |-> !padOe[PIN_PA6] && !padOe[PIN_PA7]) // [R14]
        else $error("crystal pin driven by port");
    AST_PB3_CMP: assert property (comparatorPinEnable
        && !portBOpendrainCtrl[3] |=> padOe[PIN_PB3]
        && padOut[PIN_PB3] == $past(comparatorOut)) // [R17]
        else $error("comparator not on PB3");
    AST_IR_OFF: assert property (!irCarrierEnable && portBDirection[1]
        && !(pwmFiveOutEnable && !pwmFiveOnPa1) |=> !padOe[PIN_PB1]) // [R12]
        else $error("PB1 driven with IR disabled and pin input");
    AST_RESET_PIN: assert property (resetPinCfg && !pinLevel[PIN_PA5]
        |=> !extResetReqN) // [R13]
        else $error("low reset pin did not request reset");

endmodule : io_port_pin_function_mux

// File: verification/board_model.sv
// Board model: resolves each pad from device drive, board drive and pulls
`timescale 1ns/100ps
module board_model
    import io_port_pkg::*;
(
    // Clock
    input  wire logic                clk,
    // Device side of the pads
    input  wire logic [NUM_PINS-1:0] padOut,
    input  wire logic [NUM_PINS-1:0] padOe,
    input  wire logic [NUM_PINS-1:0] pullHighEn,
    input  wire logic [NUM_PINS-1:0] pullLowEn,
    // Board drivers
    input  wire logic [NUM_PINS-1:0] extEn,
    input  wire logic [NUM_PINS-1:0] extVal,
    // Resolved pad levels
    output logic      [NUM_PINS-1:0] padIn
);
    logic [NUM_PINS-1:0] floatV = '0;

    // Undriven pads wander every cycle
    always_ff @(posedge clk) floatV <= ~floatV;

    // Device first, then board, then pulls, else floating
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (padOe[i]) padIn[i] = padOut[i];
            else if (extEn[i]) padIn[i] = extVal[i];
            else if (pullHighEn[i]) padIn[i] = 1'b1;
            else if (pullLowEn[i]) padIn[i] = 1'b0;
            else padIn[i] = floatV[i];
        end
    end
endmodule : board_model

// File: verification/io_port_pin_function_mux_test.sv
// Self-checking bench for the fourteen-pin port mux
`timescale 1ns/100ps
module io_port_pin_function_mux_test;
    // Design and board model outputs
    logic [13:0] padIn, padOut, padOe, pullHighEn, pullLowEn;
    logic [7:0]  portADataRd;
    logic [5:0]  portBDataRd;
    logic        portChangeFlag, portChangeIrq, extInt0, extInt1;
    logic        extResetReqN, crystalPinsEn, timerZeroExtClk;
    logic        timerOneExtClk, timerThreeExtClk;
    // Bench-driven inputs
    bit          clk;
    bit          rst = 1;
    bit   [13:0] readLatchSel = '1, extEn = 14'h0133, extVal;
    bit   [7:0]  portAWrData, portAPullhighCtrl, sharedPulllowCtrl;
    bit   [7:0]  portAWakeEnable, portADirection = '1;
    bit   [5:0]  portBWrData, portBPullhighCtrl, portBOpendrainCtrl;
    bit   [5:0]  portBWakeEnable, portBDirection = '1;
    bit          portAWr, portBWr, portChangeIntEnable, globalIntEnable;
    bit          portChangeFlagClr, extInt0Select, extInt1Select, resetPinCfg;
    bit          extHighCrystal, extLowCrystal, internalHighRc, internalLowRc;
    bit          clkOutCfg, instrClk, timerZeroSourceSel, timerZeroLowclkSel;
    bit          timerOneSourceSel, timerThreeSourceSel, irCarrierEnable;
    bit          irCarrier, comparatorPinEnable, comparatorOut, pwmOne;
    bit          pwmOneOutEnable, pwmOneOnPa4, buzzerOneEnable, buzzerOne;
    bit          pwmTwoOutEnable, pwmTwoOnPa0, pwmTwo, pwmFourOutEnable;
    bit          pwmFourActiveLow, pwmFourOnPb5, pwmFour, pwmFiveOutEnable;
    bit          pwmFiveActiveLow, pwmFiveOnPa1, pwmFive;
    int          errCount, nTests, cycles;

    io_port_pin_function_mux io_port_pin_function_mux_i (.*);
    board_model              board_model_i (.*);

    // 200 MHz clock
    initial forever #2.5 clk = ~clk;

    task automatic chk(string what, logic [13:0] seen, logic [13:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Wait n edges, then look at settled outputs
    task automatic wt(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wt

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errCount++;
            summarize();
        end
    end

    // Test sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        wt(1);
        chk("padOe", padOe, 0);
        chk("flag", portChangeFlag, 0);
        $display("test reset done");
        @(posedge clk);
        portAPullhighCtrl <= 8'hFF;
        portBPullhighCtrl <= 6'h3F;
        wt(3);
        chk("pullHigh", pullHighEn, 14'h3FDF);
        chk("pullLow", pullLowEn, 14'h0020);
        @(posedge clk);
        portAPullhighCtrl <= 8'h00;
        portBPullhighCtrl <= 6'h00;
        sharedPulllowCtrl <= 8'hFF;
        wt(3);
        chk("pullLow", pullLowEn, 14'h0F0F);
        @(posedge clk);
        portADirection <= 8'h00;
        wt(3);
        chk("pullLow", pullLowEn, 14'h0F00);
        $display("test pulls done");
        @(posedge clk);
        {portAWr, portBWr, portBDirection} <= 8'hC0;
        {portAWrData, portBWrData} <= 14'h25AA;
        @(posedge clk);
        {portAWr, portBWr} <= 2'h0;
        wt(3);
        chk("padOut", padOut, 14'h2A96);
        chk("padOe", padOe, 14'h3FFF);
        chk("latchA", portADataRd, 14'h0096);
        @(posedge clk);
        readLatchSel <= '0;
        wt(3);
        chk("pinRead", {portBDataRd, portADataRd}, 14'h2A96);
        @(posedge clk);
        portBOpendrainCtrl <= 6'h3F;
        wt(3);
        chk("odOe", padOe[13:8], 14'h0015);
        $display("test data done");
        @(posedge clk);
        {portADirection, portBDirection, portBOpendrainCtrl} <= 20'hFFFC0;
        {portAWakeEnable, portChangeIntEnable, globalIntEnable} <= 10'h007;
        wt(8);
        chk("flag", portChangeFlag, 0);
        @(posedge clk);
        extVal[0] <= 1;
        wt(8);
        chk("flagIrq", {portChangeFlag, portChangeIrq}, 3);
        @(posedge clk);
        globalIntEnable <= 0;
        wt(2);
        chk("flagIrq", {portChangeFlag, portChangeIrq}, 2);
        @(posedge clk);
        extVal[0] <= 0;
        repeat (4) @(posedge clk);
        portChangeFlagClr <= 1;
        wt(1);
        chk("flag", portChangeFlag, 1);
        @(posedge clk);
        portChangeFlagClr <= 0;
        wt(2);
        chk("flag", portChangeFlag, 0);
        @(posedge clk);
        {portAWakeEnable, extInt0Select, portBWakeEnable, extVal[8]} <= 16'h0083;
        wt(8);
        chk("extInt", {portChangeFlag, extInt0}, 1);
        $display("test change done");
        @(posedge clk);
        {comparatorPinEnable, comparatorOut, pwmOneOutEnable} <= 3'h7;
        {buzzerOneEnable, buzzerOne} <= 2'h3;
        wt(3);
        chk("pb3", padOut[11], 1);
        @(posedge clk);
        comparatorPinEnable <= 0;
        wt(3);
        chk("pb3", {padOe[11], padOut[11]}, 2);
        @(posedge clk);
        {resetPinCfg, timerZeroSourceSel, timerOneSourceSel} <= 3'h7;
        {timerThreeSourceSel, irCarrierEnable, irCarrier, extInt1Select} <= 4'hF;
        {internalHighRc, clkOutCfg, instrClk, extVal[4], extVal[1]} <= 5'h1F;
        {pwmFiveOutEnable, pwmFiveActiveLow, pwmFive} <= 3'h7;
        {pwmTwoOutEnable, pwmTwo} <= 2'h3;
        {pwmFourOutEnable, pwmFourOnPb5, pwmFour} <= 3'h7;
        wt(8);
        chk("extReset", extResetReqN, 0);
        chk("extInt1", extInt1, 1);
        chk("pwm4", padOut[13], 1);
        chk("timer", {timerZeroExtClk, timerOneExtClk, timerThreeExtClk}, 7);
        chk("alt", padOut & 14'h0780, 14'h0680);
        @(posedge clk);
        extHighCrystal <= 1;
        wt(3);
        chk("crystal", {crystalPinsEn, padOe[7]}, 2);
        $display("test alternate done");
        summarize();
    end
endmodule : io_port_pin_function_mux_test
